// ---- core/pcr_port_command_regs.sv ----
// Command and configuration registers of the quad-port power controller.
`timescale 1ns/1ps
module pcr_port_command_regs #(
   parameter int DIV_50 = pcr_pkg::PCR_DIV_50HZ,
   parameter int DIV_60 = pcr_pkg::PCR_DIV_60HZ,
   parameter int PORTS = pcr_pkg::PCR_PORTS
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [2*PORTS-1:0] mode_in,
   input wire logic fast_off_input_n_in,
   input wire logic [PORTS-1:0] shutdown_select_in,
   input wire logic [pcr_pkg::PCR_EV_W-1:0] irq_enable_in,
   input wire logic [PORTS-1:0] class_done_in,
   input wire logic [PORTS-1:0] power_good_in,
   input wire logic [PORTS-1:0] disconnect_in,
   input wire logic [PORTS-1:0] overload_in,
   input wire logic [PORTS-1:0] foldback_in,
   input wire logic [PORTS-1:0] inrush_in,
   input wire logic [PORTS-1:0] cooldown_end_in,
   output logic irq_n_out,
   output logic sense_resistor_select_out,
   output logic sample_tick_out,
   output logic [PORTS-1:0] detect_active_out,
   output logic [PORTS-1:0] class_active_out,
   output logic [PORTS-1:0] power_on_status_out,
   output logic [PORTS-1:0] power_good_status_out,
   output logic [PORTS-1:0] detect_enable_out,
   output logic [PORTS-1:0] class_enable_out,
   output logic [PORTS-1:0] cooldown_out,
   output logic [pcr_pkg::PCR_EV_W*PORTS-1:0] event_out
);
   import pcr_pkg::*;

   logic [7:0] gen_mask;
   logic irq_released;
   logic [PORTS-1:0] ev_new;
   logic [PCR_EV_W*PORTS-1:0] ev_all;

   // Command decode; every command bit lives for the write cycle only.
   wire wr_mask = reg_wr_in && (reg_addr_in == PCR_CMD_GEN_MASK1);
   wire wr_restart = reg_wr_in && (reg_addr_in == PCR_CMD_RESTART);
   wire wr_power = reg_wr_in && (reg_addr_in == PCR_CMD_POWER);
   wire wr_reset = reg_wr_in && (reg_addr_in == PCR_CMD_RESET);
   wire [PORTS-1:0] det_rst = {PORTS{wr_restart}} & reg_wdata_in[PORTS-1:0];
   wire [PORTS-1:0] cls_rst = {PORTS{wr_restart}} & reg_wdata_in[PORTS+3:4];
   wire [PORTS-1:0] on_stb = {PORTS{wr_power}} & reg_wdata_in[PORTS-1:0];
   wire [PORTS-1:0] off_stb = {PORTS{wr_power}} & reg_wdata_in[PORTS+3:4];
   wire [PORTS-1:0] prst_stb = {PORTS{wr_reset}} & reg_wdata_in[PORTS-1:0];
   wire clr_all = wr_reset & reg_wdata_in[PCR_RST_CLR_ALL];
   wire release_stb = wr_reset & reg_wdata_in[PCR_RST_RELEASE];
   wire reset_all = wr_reset & reg_wdata_in[PCR_RST_ALL];
   wire shut_active = ~fast_off_input_n_in;

   // Interrupt request, gated by the mask register and the release latch.
   wire [PCR_EV_W*PORTS-1:0] irq_bits = ev_all & {PORTS{irq_enable_in}};
   wire irq_pending = |irq_bits;
   wire any_new = |ev_new;
   wire irq_gate = gen_mask[PCR_GM1_IRQ_GATE];
   wire next_released = ~any_new & (irq_released | clr_all | release_stb);
   assign irq_n_out = ~(irq_gate & irq_pending & ~irq_released);

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) gen_mask <= PCR_GM1_RESET;
      else if (reset_all) gen_mask <= PCR_GM1_RESET;
      else if (wr_mask) gen_mask <= reg_wdata_in;
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) irq_released <= 1'b0;
      else if (reset_all) irq_released <= 1'b0;
      else irq_released <= next_released;
   end

   // Only the mask register reads back; command registers read as zero.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) reg_rdata_out <= 8'h00;
      else if (reg_rd_in) reg_rdata_out <= (reg_addr_in == PCR_CMD_GEN_MASK1) ? gen_mask : 8'h00;
   end

   assign sense_resistor_select_out = gen_mask[PCR_GM1_SENSE];
   assign event_out = ev_all;

   pcr_rate_gen #(
      .DIV_50(DIV_50),
      .DIV_60(DIV_60)
   ) u_rate (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .soft_rst_in(reset_all),
      .mains_in(gen_mask[PCR_GM1_MAINS]),
      .tick_out(sample_tick_out)
   );

   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : g_port
         pcr_port_ctrl u_port (
            .clk_sys_in(clk_sys_in),
            .nrst_in(nrst_in),
            .soft_rst_in(reset_all),
            .mode_in(pcr_mode_t'(mode_in[2*g+1:2*g])),
            .sample_tick_in(sample_tick_out),
            .det_rst_in(det_rst[g]),
            .cls_rst_in(cls_rst[g]),
            .off_in(off_stb[g]),
            .on_in(on_stb[g]),
            .prst_in(prst_stb[g]),
            .shut_in(shut_active & shutdown_select_in[g]),
            .clr_ev_in(clr_all),
            .class_done_in(class_done_in[g]),
            .power_good_in(power_good_in[g]),
            .disconnect_in(disconnect_in[g]),
            .overload_in(overload_in[g]),
            .foldback_in(foldback_in[g]),
            .inrush_in(inrush_in[g]),
            .cool_end_in(cooldown_end_in[g]),
            .detect_active_out(detect_active_out[g]),
            .class_active_out(class_active_out[g]),
            .power_on_status_out(power_on_status_out[g]),
            .power_good_status_out(power_good_status_out[g]),
            .detect_enable_out(detect_enable_out[g]),
            .class_enable_out(class_enable_out[g]),
            .cooldown_out(cooldown_out[g]),
            .event_out(ev_all[PCR_EV_W*g +: PCR_EV_W]),
            .ev_new_out(ev_new[g])
         );
      end
   endgenerate

   // Checks on the command behaviour.
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   property p_gate_off;
      !irq_gate |-> irq_n_out;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("interrupt asserted with gate clear");

   property p_gate_on;
      irq_gate && irq_pending && !irq_released |-> !irq_n_out;
   endproperty
   a_gate_on: assert property (p_gate_on) else $error("interrupt missing with gate set");

   property p_mask_keeps_events;
      wr_mask && !clr_all && (prst_stb == '0) && !shut_active |=> ($past(ev_all) & ~ev_all) == '0;
   endproperty
   a_mask_keeps_events: assert property (p_mask_keeps_events) else $error("mask write disturbed events");

   property p_sense_follow;
      wr_mask |=> sense_resistor_select_out == $past(reg_wdata_in[PCR_GM1_SENSE]);
   endproperty
   a_sense_follow: assert property (p_sense_follow) else $error("sense select not taken");

   sequence s_clear_all;
      clr_all && !any_new && !reset_all && prst_stb == '0 && !shut_active && detect_active_out == '0
         && (class_done_in | disconnect_in | overload_in | foldback_in | inrush_in) == '0;
   endsequence
   property p_clear_all;
      s_clear_all |=> irq_n_out && ev_all == '0;
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("clear-all left interrupt active");

   property p_release_keeps;
      release_stb && !clr_all && !any_new && !reset_all |=> irq_n_out && ev_all == $past(ev_all);
   endproperty
   a_release_keeps: assert property (p_release_keeps) else $error("release changed events");

   property p_reset_all;
      reset_all |=> gen_mask == PCR_GM1_RESET && power_on_status_out == '0 && ev_all == '0
         && cooldown_out == '0 && !irq_released;
   endproperty
   a_reset_all: assert property (p_reset_all) else $error("reset-all not like power-up");

   generate
      for (g = 0; g < PORTS; g++) begin : g_chk
         wire pmanual = (mode_in[2*g+1:2*g] == PCR_MODE_MANUAL);
         wire pauto = pcr_auto_like(pcr_mode_t'(mode_in[2*g+1:2*g]));
         wire poff = (mode_in[2*g+1:2*g] == PCR_MODE_OFF);
         wire pfault = overload_in[g] | foldback_in[g] | inrush_in[g];
         wire pshut = shut_active & shutdown_select_in[g];

         property p_both_off;
            off_stb[g] && on_stb[g] && !poff |=> !power_on_status_out[g];
         endproperty
         a_both_off: assert property (p_both_off) else $error("on and off together left port on");

         property p_cool_no_on;
            on_stb[g] && pauto && cooldown_out[g] && !power_on_status_out[g] |=> !power_on_status_out[g];
         endproperty
         a_cool_no_on: assert property (p_cool_no_on) else $error("port powered during cool-down");

         property p_manual_on;
            on_stb[g] && !off_stb[g] && pmanual && !pshut && !pfault && !reset_all |=> power_on_status_out[g];
         endproperty
         a_manual_on: assert property (p_manual_on) else $error("manual power-on not immediate");

         property p_mode_off_ignores;
            poff && !power_on_status_out[g] |=> !power_on_status_out[g];
         endproperty
         a_mode_off_ignores: assert property (p_mode_off_ignores) else $error("off mode port powered");

         sequence s_powered_reset;
            prst_stb[g] && power_on_status_out[g] && !reset_all && !clr_all;
         endsequence
         property p_reset_powered;
            s_powered_reset |=> !power_on_status_out[g] && !power_good_status_out[g] && !cooldown_out[g]
               && ev_all[PCR_EV_W*g+PCR_EV_PGC] && ev_all[PCR_EV_W*g+PCR_EV_PEC]
               && !detect_enable_out[g] && !class_enable_out[g];
         endproperty
         a_reset_powered: assert property (p_reset_powered) else $error("port reset incomplete");

         property p_off_clears;
            off_stb[g] && !poff && !reset_all && !pfault |=> !power_on_status_out[g] && !detect_enable_out[g]
               && ev_all[PCR_EV_W*g+PCR_EV_DET] == 1'b0 && ev_all[PCR_EV_W*g+PCR_EV_STRT] == 1'b0;
         endproperty
         a_off_clears: assert property (p_off_clears) else $error("power-off did not clear port");

         property p_cool_idle;
            cooldown_out[g] |-> !detect_active_out[g] && !class_active_out[g];
         endproperty
         a_cool_idle: assert property (p_cool_idle) else $error("port ran a cycle in cool-down");

         sequence s_held_restart;
            det_rst[g] && pmanual && cooldown_out[g] && !cooldown_end_in[g];
         endsequence
         property p_restart_held;
            s_held_restart ##1 (cooldown_out[g] && pmanual) [*3] |-> !detect_active_out[g];
         endproperty
         a_restart_held: assert property (p_restart_held) else $error("restart ran in cool-down");

         property p_semi_restart;
            det_rst[g] && pauto && !reset_all |=> detect_enable_out[g];
         endproperty
         a_semi_restart: assert property (p_semi_restart) else $error("restart did not set enable");

         property p_detect_len;
            $rose(ev_all[PCR_EV_W*g+PCR_EV_DET])
               |-> $past(sample_tick_out) && $past(g_port[g].u_port.smp_cnt) == 4'hF;
         endproperty
         a_detect_len: assert property (p_detect_len) else $error("detection sample count wrong");
      end
   endgenerate
endmodule // pcr_port_command_regs

// ---- core/pcr_pkg.sv ----
// Constants, types and helpers shared by the port command register block.
package pcr_pkg;
   localparam int PCR_CLK_HZ = 50_000_000;
   localparam int PCR_PORTS = 4;
   localparam logic [7:0] PCR_CMD_GEN_MASK1 = 8'h17;
   localparam logic [7:0] PCR_CMD_RESTART = 8'h18;
   localparam logic [7:0] PCR_CMD_POWER = 8'h19;
   localparam logic [7:0] PCR_CMD_RESET = 8'h1A;
   localparam logic [7:0] PCR_GM1_RESET = 8'h80;
   localparam int PCR_GM1_IRQ_GATE = 7;
   localparam int PCR_GM1_MAINS = 4;
   localparam int PCR_GM1_SENSE = 0;
   localparam int PCR_RST_CLR_ALL = 7;
   localparam int PCR_RST_RELEASE = 6;
   localparam int PCR_RST_ALL = 4;
   localparam int PCR_RATE_60HZ = 960;
   localparam int PCR_RATE_50HZ = 800;
   localparam int PCR_DIV_60HZ = PCR_CLK_HZ / PCR_RATE_60HZ;
   localparam int PCR_DIV_50HZ = PCR_CLK_HZ / PCR_RATE_50HZ;
   localparam int PCR_SAMPLES = 16;
   localparam int PCR_EV_W = 8;
   localparam int PCR_EV_PGC = 7;
   localparam int PCR_EV_PEC = 6;
   localparam int PCR_EV_CLS = 5;
   localparam int PCR_EV_DET = 4;
   localparam int PCR_EV_DISF = 3;
   localparam int PCR_EV_ICUT = 2;
   localparam int PCR_EV_ILIM = 1;
   localparam int PCR_EV_STRT = 0;
   typedef enum logic [1:0] {PCR_MODE_OFF = 2'h0, PCR_MODE_MANUAL = 2'h1, PCR_MODE_SEMI = 2'h2,
      PCR_MODE_AUTO = 2'h3} pcr_mode_t;
   typedef enum logic [3:0] {PCR_ST_IDLE = 4'h1, PCR_ST_DETECT = 4'h2, PCR_ST_CLASS = 4'h4,
      PCR_ST_POWERED = 4'h8} pcr_state_t;
   function automatic logic pcr_auto_like(input pcr_mode_t m);
      return (m == PCR_MODE_SEMI) || (m == PCR_MODE_AUTO);
   endfunction
endpackage

// ---- core/pcr_rate_gen.sv ----
// Detection sample-rate divider giving one tick per conversion.
`timescale 1ns/1ps
module pcr_rate_gen #(
   parameter int DIV_50 = pcr_pkg::PCR_DIV_50HZ,
   parameter int DIV_60 = pcr_pkg::PCR_DIV_60HZ
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic soft_rst_in,
   input wire logic mains_in,
   output logic tick_out
);
   import pcr_pkg::*;
   logic [15:0] cnt;
   wire [15:0] reload = mains_in ? 16'(DIV_60 - 1) : 16'(DIV_50 - 1);
   wire [15:0] next_cnt = (cnt == 16'h0000) ? reload : 16'(cnt - 16'h0001);
   assign tick_out = (cnt == 16'h0000);
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) cnt <= 16'h0000;
      else if (soft_rst_in) cnt <= 16'h0000;
      else cnt <= next_cnt;
   end
   property p_rate_reload;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      tick_out && !soft_rst_in |=> cnt == ($past(mains_in) ? 16'(DIV_60 - 1) : 16'(DIV_50 - 1));
   endproperty
   a_rate_reload: assert property (p_rate_reload) else $error("sample divider reload wrong");
endmodule // pcr_rate_gen

// ---- core/pcr_port_ctrl.sv ----
// Per-port command sequencer: detection, classification, power and events.
`timescale 1ns/1ps
module pcr_port_ctrl (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic soft_rst_in,
   input wire pcr_pkg::pcr_mode_t mode_in,
   input wire logic sample_tick_in,
   input wire logic det_rst_in,
   input wire logic cls_rst_in,
   input wire logic off_in,
   input wire logic on_in,
   input wire logic prst_in,
   input wire logic shut_in,
   input wire logic clr_ev_in,
   input wire logic class_done_in,
   input wire logic power_good_in,
   input wire logic disconnect_in,
   input wire logic overload_in,
   input wire logic foldback_in,
   input wire logic inrush_in,
   input wire logic cool_end_in,
   output logic detect_active_out,
   output logic class_active_out,
   output logic power_on_status_out,
   output logic power_good_status_out,
   output logic detect_enable_out,
   output logic class_enable_out,
   output logic cooldown_out,
   output logic [pcr_pkg::PCR_EV_W-1:0] event_out,
   output logic ev_new_out
);
   import pcr_pkg::*;
   pcr_state_t state, next_state;
   logic [3:0] smp_cnt;
   logic cool, pend_det, pend_cls, det_en, cls_en, pg_stat;
   logic [PCR_EV_W-1:0] ev;
   wire manual = (mode_in == PCR_MODE_MANUAL);
   wire autoish = pcr_auto_like(mode_in);
   wire powered = (state == PCR_ST_POWERED);
   wire kill = prst_in | shut_in | (off_in & (mode_in != PCR_MODE_OFF));
   wire fault = overload_in | foldback_in | inrush_in;
   wire on_ok = on_in & ~kill & ~fault & ~powered & (mode_in != PCR_MODE_OFF) & (manual | ~cool);
   wire may_run = ~cool & ~kill & ~fault & ~on_ok;
   wire go_det = may_run & ((manual & pend_det) | (autoish & det_en));
   wire go_cls = may_run & manual & pend_cls;
   wire smp_last = sample_tick_in & (smp_cnt == 4'(PCR_SAMPLES - 1));
   wire det_done = (state == PCR_ST_DETECT) & smp_last & may_run;
   wire cls_done = (state == PCR_ST_CLASS) & class_done_in & may_run;
   wire pwr_edge = (powered & (kill | fault)) | (~powered & on_ok);
   wire [PCR_EV_W-1:0] ev_set = {pwr_edge, pwr_edge, cls_done, det_done, disconnect_in & powered,
      overload_in, foldback_in, inrush_in};
   wire [PCR_EV_W-1:0] ev_clr = {2'b00, {6{kill}}} | {PCR_EV_W{clr_ev_in}};
   wire [PCR_EV_W-1:0] next_ev = ev_set | (ev & ~ev_clr);
   wire next_pend_det = (det_rst_in & manual) | (pend_det & ~kill & ~(state == PCR_ST_IDLE & go_det));
   wire next_pend_cls = (cls_rst_in & manual) | (pend_cls & ~kill & ~(next_state == PCR_ST_CLASS));
   wire next_det_en = (det_rst_in & autoish) | (det_en & ~kill);
   wire next_cls_en = (cls_rst_in & autoish) | (cls_en & ~kill);
   wire next_cool = fault | (cool & ~cool_end_in & ~prst_in);
   wire [3:0] next_smp = (state == PCR_ST_DETECT && next_state == PCR_ST_DETECT) ?
      4'(smp_cnt + {3'h0, sample_tick_in}) : 4'h0;
   always_comb begin
      next_state = state;
      if (kill | fault) next_state = PCR_ST_IDLE;
      else if (on_ok) next_state = PCR_ST_POWERED;
      else begin
         case (state)
            PCR_ST_IDLE: begin
               if (go_det) next_state = PCR_ST_DETECT;
               else if (go_cls) next_state = PCR_ST_CLASS;
            end
            PCR_ST_DETECT: if (det_done) next_state = (autoish & cls_en) | (manual & pend_cls) ? PCR_ST_CLASS : PCR_ST_IDLE;
            PCR_ST_CLASS: if (cls_done) next_state = PCR_ST_IDLE;
            PCR_ST_POWERED: next_state = PCR_ST_POWERED;
            default: next_state = PCR_ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= PCR_ST_IDLE;
         {smp_cnt, cool, pend_det, pend_cls, det_en, cls_en, pg_stat, ev} <= '0;
      end else if (soft_rst_in) begin
         state <= PCR_ST_IDLE;
         {smp_cnt, cool, pend_det, pend_cls, det_en, cls_en, pg_stat, ev} <= '0;
      end else begin
         state <= next_state;
         {smp_cnt, cool, pend_det, pend_cls, det_en, cls_en} <= {next_smp, next_cool, next_pend_det,
            next_pend_cls, next_det_en, next_cls_en};
         pg_stat <= (next_state == PCR_ST_POWERED) & power_good_in;
         ev <= next_ev;
      end
   end
   assign detect_active_out = (state == PCR_ST_DETECT);
   assign class_active_out = (state == PCR_ST_CLASS);
   assign power_on_status_out = powered;
   assign power_good_status_out = pg_stat;
   assign detect_enable_out = det_en;
   assign class_enable_out = cls_en;
   assign cooldown_out = cool;
   assign event_out = ev;
   assign ev_new_out = |(ev_set & ~ev);
endmodule // pcr_port_ctrl

// ---- tb/pcr_host.sv ----
// Host processor model issuing single-byte register commands.
`timescale 1ns/1ps
module pcr_host (
   input wire logic clk_sys_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out
);
   initial begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end
   // No enable write is ever sent, so no spacing after commands is owed.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge clk_sys_in);
      reg_wr_out = 1'b0;
      reg_wdata_out = ~d;
      @(negedge clk_sys_in);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge clk_sys_in);
      reg_rd_out = 1'b0;
      @(negedge clk_sys_in);
      d = reg_rdata_in;
   endtask
endmodule // pcr_host

// ---- tb/tb.sv ----
// Self-checking testbench of the port command register block.
`timescale 1ns/1ps
module tb;
   import pcr_pkg::*;
   logic clk_sys_in, nrst_in, reg_wr_in, reg_rd_in, irq_n_out, sense_resistor_select_out, sample_tick_out;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, mode_in, irq_enable_in, d;
   logic fast_off_input_n_in;
   logic [3:0] shutdown_select_in, class_done_in, power_good_in, disconnect_in, overload_in, foldback_in;
   logic [3:0] inrush_in, cooldown_end_in, detect_active_out, class_active_out, power_on_status_out;
   logic [3:0] power_good_status_out, detect_enable_out, class_enable_out, cooldown_out;
   logic [31:0] event_out;
   int num_errors = 0;
   int num_checks = 0;
   pcr_port_command_regs #(.DIV_50(20), .DIV_60(16)) uut (.clk_sys_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mode_in, .fast_off_input_n_in, .shutdown_select_in,
      .irq_enable_in, .class_done_in, .power_good_in, .disconnect_in, .overload_in, .foldback_in, .inrush_in,
      .cooldown_end_in, .irq_n_out, .sense_resistor_select_out, .sample_tick_out, .detect_active_out,
      .class_active_out, .power_on_status_out, .power_good_status_out, .detect_enable_out,
      .class_enable_out, .cooldown_out, .event_out);
   pcr_host host (.clk_sys_in, .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
      .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in));
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   task automatic close_out();
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic tk(output int n);
      n = 0;
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (sample_tick_out !== 1'b1 && n < 100);
      if (n >= 100) begin
         num_errors++;
         close_out();
      end
   endtask
   task automatic t_mask();
      int n;
      host.rd(PCR_CMD_GEN_MASK1, d);
      chk("mask_rst", 8'h80, d);
      host.wr(PCR_CMD_GEN_MASK1, 8'h11);
      host.rd(PCR_CMD_GEN_MASK1, d);
      chk("mask_rw", 8'h11, d);
      chk("sense", 1'b1, sense_resistor_select_out);
      tk(n);
      tk(n);
      chk("gap60", 16, n);
      host.rd(PCR_CMD_RESTART, d);
      chk("wo_read", 8'h00, d);
      host.wr(PCR_CMD_RESET, 8'h10);
      host.rd(PCR_CMD_GEN_MASK1, d);
      chk("reset_all_strobe", 8'h80, d);
      chk("sense_rst", 1'b0, sense_resistor_select_out);
      tk(n);
      tk(n);
      chk("gap50", 20, n);
   endtask
   task automatic t_power();
      host.wr(PCR_CMD_GEN_MASK1, 8'h00);
      host.wr(PCR_CMD_POWER, 8'h02);
      chk("off_mode", 1'b0, power_on_status_out[1]);
      host.wr(PCR_CMD_POWER, 8'h01);
      chk("pon", 1'b1, power_on_status_out[0]);
      chk("irq_gated", 1'b1, irq_n_out);
      host.wr(PCR_CMD_GEN_MASK1, 8'h80);
      chk("irq_on", 1'b0, irq_n_out);
      chk("ev_kept", 2'b11, event_out[7:6]);
      host.wr(PCR_CMD_RESET, 8'h40);
      chk("irq_rel", 1'b1, irq_n_out);
      chk("ev_rel", 2'b11, event_out[7:6]);
      host.wr(PCR_CMD_RESET, 8'h80);
      chk("clr_all", 32'h0, event_out);
      chk("pg_first", 1'b1, power_good_status_out[0]);
      host.wr(PCR_CMD_POWER, 8'h11);
      chk("both_off", 1'b0, power_on_status_out[0]);
      chk("off_ev", 2'b11, event_out[7:6]);
      chk("off_pg", 1'b0, power_good_status_out[0]);
      host.wr(PCR_CMD_POWER, 8'h01);
      host.wr(PCR_CMD_RESET, 8'h80);
      host.wr(PCR_CMD_RESET, 8'h01);
      chk("prst", 1'b0, power_on_status_out[0]);
      chk("prst_ev", 2'b11, event_out[7:6]);
   endtask
   task automatic t_detect();
      int n;
      int i;
      n = 0;
      host.wr(PCR_CMD_RESTART, 8'h01);
      chk("det_go", 1'b1, detect_active_out[0]);
      for (i = 0; i < 2000 && detect_active_out[0] === 1'b1; i++) begin
         n += (sample_tick_out === 1'b1);
         @(negedge clk_sys_in);
      end
      if (i >= 2000) begin
         num_errors++;
         close_out();
      end
      chk("samples", 16, n);
      chk("det_ev", 1'b1, event_out[PCR_EV_DET]);
      host.wr(PCR_CMD_RESTART, 8'h10);
      chk("cls_go", 1'b1, class_active_out[0]);
      class_done_in = 4'h1;
      @(negedge clk_sys_in);
      class_done_in = 4'h0;
      @(negedge clk_sys_in);
      chk("cls_ev", 1'b1, event_out[PCR_EV_CLS]);
      chk("cls_end", 1'b0, class_active_out[0]);
      host.wr(PCR_CMD_RESTART, 8'h44);
      chk("semi_en", 1'b1, detect_enable_out[2]);
      chk("semi_cen", 1'b1, class_enable_out[2]);
      host.wr(PCR_CMD_POWER, 8'h40);
      chk("semi_clr", 1'b0, detect_enable_out[2]);
      chk("semi_cclr", 1'b0, class_enable_out[2]);
   endtask
   task automatic t_cool();
      @(negedge clk_sys_in);
      overload_in = 4'hD;
      @(negedge clk_sys_in);
      overload_in = 4'h0;
      chk("cool_set", 4'hD, cooldown_out);
      host.wr(PCR_CMD_POWER, 8'h04);
      chk("cool_semi_on", 1'b0, power_on_status_out[2]);
      host.wr(PCR_CMD_RESTART, 8'h08);
      repeat (3) @(negedge clk_sys_in);
      chk("cool_held", 1'b0, detect_active_out[3]);
      cooldown_end_in = 4'h8;
      @(negedge clk_sys_in);
      cooldown_end_in = 4'h0;
      @(negedge clk_sys_in);
      chk("cool_run", 1'b1, detect_active_out[3]);
      host.wr(PCR_CMD_POWER, 8'h01);
      chk("cool_man_on", 1'b1, power_on_status_out[0]);
      host.wr(PCR_CMD_RESET, 8'h0F);
      chk("cool_cancel", 4'h0, cooldown_out);
      chk("cool_prst", 4'h0, power_on_status_out);
   endtask
   initial begin
      nrst_in = 1'b0;
      mode_in = 8'h61;
      fast_off_input_n_in = 1'b1;
      shutdown_select_in = 4'h0;
      irq_enable_in = 8'hFF;
      power_good_in = 4'hF;
      {class_done_in, disconnect_in, overload_in, foldback_in, inrush_in, cooldown_end_in} = 24'h0;
      repeat (4) @(negedge clk_sys_in);
      nrst_in = 1'b1;
      chk("irq_idle", 1'b1, irq_n_out);
      t_mask();
      t_power();
      t_detect();
      t_cool();
      close_out();
   end
endmodule // tb
